/* design/asd_alu_shift_skip.sv */
// Purpose: executes one arithmetic/logic instruction per write of the instruction register with isAlu set
// Assumes: APB master keeps the request steady until pready; one wait state per access
// Notes: accumulators and carry flag live here so software can load and inspect them
//
// Implementation choices: register access over APB and the placing of the registers.

module asd_alu_shift_skip
  import asd_pkg::*;
#(
  parameter int unsigned NumAcc = AccCount
) (
  input wire logic clk, // 100 MHz clock
  input wire logic reset, // synchronous, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high writes
  input wire logic [AddrW-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic [31:0] prdata, // apb read data
  output logic skipNext, // last instruction-register write was an executed instruction asking to skip the next
  output logic execPulse // one cycle as an instruction executes
);
  asd_instr_s instrQ;
  asd_instr_s ins;
  logic [DataW-1:0] accQ [NumAcc];
  logic carryQ;
  logic skipQ, rejectQ, doneQ, readyQ, errQ, execQ;
  logic [31:0] rdataQ;
  logic [31:0] rdData;
  logic addrOk;
  logic wrEn;
  logic execNow;
  logic [DataW-1:0] srcVal, dstVal;
  logic carryBase;
  logic [16:0] aluSum;
  logic aluCarryOut;
  logic resultingCarry;
  logic [DataW-1:0] shiftedData;
  logic shiftedCarry;
  logic skipHit;
  logic [1:0] accIdx;

  assign ins = asd_instr_s'(pwdata[DataW-1:0]);
  assign wrEn = psel && penable && readyQ && pwrite;
  assign execNow = wrEn && (paddr == RegInstrOff) && ins.isAlu;
  assign srcVal = accQ[ins.sourceAccSelect];
  assign dstVal = accQ[ins.destAccSelect];
  assign accIdx = paddr[3:2];

  always_comb begin
    case (ins.carryBaseField)
      CbKeep: carryBase = carryQ;
      CbZero: carryBase = 1'b0;
      CbOne: carryBase = 1'b1;
      default: carryBase = ~carryQ;
    endcase
  end

  // logical functions force no carry-out so the base passes untouched
  always_comb begin
    case (ins.func)
      FnInvert: aluSum = {1'b0, ~srcVal};
      FnNegate: aluSum = {1'b0, ~srcVal} + OneWide;
      FnPass: aluSum = {1'b0, srcVal};
      FnIncrement: aluSum = {1'b0, srcVal} + OneWide;
      FnAddComplement: aluSum = {1'b0, dstVal} + {1'b0, ~srcVal};
      FnSubtract: aluSum = {1'b0, dstVal} + {1'b0, ~srcVal} + OneWide;
      FnAdd: aluSum = {1'b0, dstVal} + {1'b0, srcVal};
      default: aluSum = {1'b0, dstVal & srcVal};
    endcase
  end

  assign aluCarryOut = aluSum[16];
  assign resultingCarry = carryBase ^ aluCarryOut;

  // bit 0 of the instruction numbering is the word's msb, so left moves toward [15]
  always_comb begin
    case (ins.shiftField)
      ShLeft: {shiftedCarry, shiftedData} = {aluSum[15:0], resultingCarry};
      ShRight: {shiftedData, shiftedCarry} = {resultingCarry, aluSum[15:0]};
      ShSwap: {shiftedCarry, shiftedData} = {resultingCarry, aluSum[7:0], aluSum[15:8]};
      default: {shiftedCarry, shiftedData} = {resultingCarry, aluSum[15:0]};
    endcase
  end

  // tests look at the shifter output, not at what was stored
  always_comb begin
    case (ins.skipTestField)
      SkNever: skipHit = 1'b0;
      SkAlways: skipHit = 1'b1;
      SkCarryZero: skipHit = ~shiftedCarry;
      SkCarrySet: skipHit = shiftedCarry;
      SkResultZero: skipHit = (shiftedData == '0);
      SkResultNonzero: skipHit = (shiftedData != '0);
      SkEitherZero: skipHit = ~shiftedCarry || (shiftedData == '0);
      default: skipHit = shiftedCarry && (shiftedData != '0);
    endcase
  end

  for (genvar g = 0; g < NumAcc; g++) begin : gAcc
    always_ff @(posedge clk) begin
      if (reset) begin
        accQ[g] <= AccReset;
      end else if (execNow && !ins.noWritebackBit && ins.destAccSelect == g) begin
        accQ[g] <= shiftedData;
      end else if (wrEn && paddr == RegAccBaseOff + AddrW'(4 * g)) begin
        accQ[g] <= pwdata[DataW-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      carryQ <= CarryReset;
    end else if (execNow && !ins.noWritebackBit) begin
      carryQ <= shiftedCarry;
    end else if (wrEn && paddr == RegCarryOff) begin
      carryQ <= pwdata[0];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      instrQ <= asd_instr_s'(InstrReset);
      skipQ <= 1'b0;
      rejectQ <= 1'b0;
      doneQ <= 1'b0;
      execQ <= 1'b0;
    end else begin
      execQ <= execNow;
      if (wrEn && paddr == RegInstrOff) begin
        instrQ <= ins;
        rejectQ <= ~ins.isAlu;
        doneQ <= ins.isAlu;
        skipQ <= ins.isAlu && skipHit;
      end
    end
  end

  // one wait state lets read data come straight from a flop
  always_comb begin
    addrOk = 1'b1;
    rdData = 32'h00000000;
    if (paddr == RegInstrOff) begin
      rdData[DataW-1:0] = instrQ;
    end else if (paddr == RegStatusOff) begin
      rdData[StSkipBit] = skipQ;
      rdData[StCarryBit] = carryQ;
      rdData[StRejectBit] = rejectQ;
      rdData[StDoneBit] = doneQ;
    end else if (paddr == RegCarryOff) begin
      rdData[0] = carryQ;
    end else if (paddr >= RegAccBaseOff && paddr <= RegAccLastOff && paddr[1:0] == 2'b00) begin
      rdData[DataW-1:0] = accQ[accIdx];
    end else begin
      addrOk = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      readyQ <= 1'b0;
      errQ <= 1'b0;
      rdataQ <= 32'h00000000;
    end else if (psel && penable && !readyQ) begin
      readyQ <= 1'b1;
      errQ <= ~addrOk;
      rdataQ <= (addrOk && !pwrite) ? rdData : 32'h00000000;
    end else begin
      readyQ <= 1'b0;
      errQ <= 1'b0;
    end
  end

  assign pready = readyQ;
  assign pslverr = errQ;
  assign prdata = rdataQ;
  assign skipNext = skipQ;
  assign execPulse = execQ;
endmodule

/* pkg/asd_pkg.sv */
// Purpose: constants and types for the arithmetic/logic, shift and skip datapath
// Assumes: 16-bit words, instruction bit 0 is the word's most significant bit
// Notes: register offsets are byte addresses on a 32-bit APB
package asd_pkg;
  localparam int unsigned DataW = 16;
  localparam int unsigned AccCount = 4;
  localparam int unsigned AddrW = 8;

  localparam logic [7:0] RegInstrOff = 8'h00;
  localparam logic [7:0] RegStatusOff = 8'h04;
  localparam logic [7:0] RegCarryOff = 8'h08;
  localparam logic [7:0] RegAccBaseOff = 8'h10;
  localparam logic [7:0] RegAccLastOff = 8'h1C;

  localparam int unsigned StSkipBit = 0;
  localparam int unsigned StCarryBit = 1;
  localparam int unsigned StRejectBit = 2;
  localparam int unsigned StDoneBit = 3;

  localparam logic [15:0] InstrReset = 16'h0000;
  localparam logic [15:0] AccReset = 16'h0000;
  localparam logic CarryReset = 1'b0;
  localparam logic [16:0] OneWide = 17'h00001;

  typedef enum logic [2:0] {
    FnInvert = 3'b000,
    FnNegate = 3'b001,
    FnPass = 3'b010,
    FnIncrement = 3'b011,
    FnAddComplement = 3'b100,
    FnSubtract = 3'b101,
    FnAdd = 3'b110,
    FnAnd = 3'b111
  } asd_func_e;

  typedef enum logic [1:0] {
    ShNone = 2'b00,
    ShLeft = 2'b01,
    ShRight = 2'b10,
    ShSwap = 2'b11
  } asd_shift_e;

  typedef enum logic [1:0] {
    CbKeep = 2'b00,
    CbZero = 2'b01,
    CbOne = 2'b10,
    CbInvert = 2'b11
  } asd_carry_e;

  typedef enum logic [2:0] {
    SkNever = 3'b000,
    SkAlways = 3'b001,
    SkCarryZero = 3'b010,
    SkCarrySet = 3'b011,
    SkResultZero = 3'b100,
    SkResultNonzero = 3'b101,
    SkEitherZero = 3'b110,
    SkBothNonzero = 3'b111
  } asd_skip_e;

  // field order follows the instruction word from its most significant bit down
  typedef struct packed {
    logic isAlu;
    logic [1:0] sourceAccSelect;
    logic [1:0] destAccSelect;
    asd_func_e func;
    asd_shift_e shiftField;
    asd_carry_e carryBaseField;
    logic noWritebackBit;
    asd_skip_e skipTestField;
  } asd_instr_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [AddrW-1:0] paddr;
    logic [31:0] pwdata;
  } asd_apb_req_s;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } asd_apb_rsp_s;
endpackage

/* verification/asd_alu_shift_skip_checker.sv */
// Purpose: port checker for the datapath
// Assumes: one wait state per apb access
// Notes: bound at the foot
module asd_alu_shift_skip_checker
  import asd_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // direction
  input wire logic [AddrW-1:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] prdata, // read data
  input wire logic skipNext, // skip level
  input wire logic execPulse // exec pulse
);
  wire logic instrWr = psel & penable & pready & pwrite & (paddr == RegInstrOff);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_exec_follows: assert property (instrWr && pwdata[15] |=> execPulse)
    else $error("no exec pulse");
  a_reject_quiet: assert property (instrWr && !pwdata[15] |=> !execPulse && !skipNext)
    else $error("rejected word acted");
  a_exec_cause: assert property (execPulse |-> $past(instrWr) ##1 !execPulse)
    else $error("stray exec pulse");
  a_skip_never: assert property (instrWr && pwdata[15] && pwdata[2:0] == 3'h0 |=> !skipNext)
    else $error("skip on code zero");
  a_skip_always: assert property (instrWr && pwdata[15] && pwdata[2:0] == 3'h1 |=> skipNext)
    else $error("no skip on code one");
  a_skip_holds: assert property (!instrWr |=> $stable(skipNext))
    else $error("skip moved");
  c_exec: cover property (instrWr && pwdata[15]);
  c_error: cover property (pslverr);
  c_skip: cover property (execPulse && skipNext);
endmodule

bind asd_alu_shift_skip asd_alu_shift_skip_checker i_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .skipNext(skipNext), .execPulse(execPulse));

/* verification/asd_alu_shift_skip_tb.sv */
// Purpose: sweeps functions, shifts, carry bases and skips
// Assumes: src acc 1, dest acc 2
// Notes: expected values come from a local model
module asd_alu_shift_skip_tb
  import asd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, reset = 1'b1, psel, penable, pwrite, pready, pslverr, skipNext, execPulse;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int failures = 0, checked = 0;
  logic [15:0] sv [4] = '{16'h0000, 16'h9ABC, 16'hFFFF, 16'h1234};
  logic [15:0] dv [4] = '{16'h8765, 16'h9ABC, 16'h0001, 16'hFEDC};
  always #5 clk = ~clk;
  asd_alu_shift_skip i_asd_alu_shift_skip (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .skipNext(skipNext), .execPulse(execPulse));
  asd_seq_model i_asd_seq_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata));
  task automatic print_verdict();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic late;
    i_asd_seq_model.xfer(w, a, d, q, e, late);
    if (late) begin
      failures++;
      print_verdict();
    end
  endtask
  function automatic logic [17:0] model(logic [15:0] ins, logic [15:0] s, logic [15:0] d, logic c);
    logic [16:0] x;
    logic [7:0] t;
    logic cb, cr, cn, z;
    logic [15:0] o;
    cb = ins[5:4] == 2'h0 ? c : ins[5:4] == 2'h1 ? 1'b0 : ins[5:4] == 2'h2 ? 1'b1 : ~c;
    case (ins[10:8])
      3'h0: x = {1'b0, ~s};
      3'h1: x = {1'b0, ~s} + 17'h00001;
      3'h2: x = {1'b0, s};
      3'h3: x = {1'b0, s} + 17'h00001;
      3'h4: x = {1'b0, d} + {1'b0, ~s};
      3'h5: x = {1'b0, d} + {1'b0, ~s} + 17'h00001;
      3'h6: x = {1'b0, d} + {1'b0, s};
      default: x = {1'b0, s & d};
    endcase
    cr = cb ^ x[16];
    case (ins[7:6])
      2'h1: {cn, o} = {x[15:0], cr};
      2'h2: {o, cn} = {cr, x[15:0]};
      2'h3: {cn, o} = {cr, x[7:0], x[15:8]};
      default: {cn, o} = {cr, x[15:0]};
    endcase
    z = o == 16'h0000;
    t = {cn & ~z, ~cn | z, ~z, z, cn, ~cn, 1'b1, 1'b0};
    return {t[ins[2:0]], cn, o};
  endfunction
  logic [17:0] r;
  initial begin
    logic [15:0] ins;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 128; i++) begin
      ins = {1'b1, 2'h1, 2'h2, i[2:0], i[4:3], i[6:5], i[0] ^ i[5], i[6:4] ^ i[2:0]};
      bus(1'b1, RegAccBaseOff + 8'h04, {16'h0000, sv[i[4:3]]});
      bus(1'b1, RegAccBaseOff + 8'h08, {16'h0000, dv[i[4:3]]});
      bus(1'b1, RegCarryOff, {31'h00000000, i[1]});
      bus(1'b1, RegInstrOff, {16'h0000, ins});
      r = model(ins, sv[i[4:3]], dv[i[4:3]], i[1]);
      chk({31'h00000000, skipNext}, {31'h00000000, r[17]});
      bus(1'b0, RegAccBaseOff + 8'h08, 32'h00000000);
      chk(q, {16'h0000, ins[3] ? dv[i[4:3]] : r[15:0]});
      bus(1'b0, RegCarryOff, 32'h00000000);
      chk(q, {31'h00000000, ins[3] ? i[1] : r[16]});
    end
    $display("test sweep done");
    bus(1'b1, RegInstrOff, 32'h00007FF9);
    chk({31'h00000000, skipNext}, 32'h00000000);
    bus(1'b0, 8'h0C, 32'h00000000);
    chk({31'h00000000, e}, 32'h00000001);
    chk(q, 32'h00000000);
    bus(1'b0, RegInstrOff, 32'h00000000);
    chk(q, 32'h00007FF9);
    bus(1'b0, RegStatusOff, 32'h00000000);
    chk(q, {28'h0000000, 1'b0, 1'b1, r[16], 1'b0});
    $display("test reject done");
    print_verdict();
  end
endmodule

/* verification/asd_seq_model.sv */
// Purpose: sequencer side, drives apb transfers
// Assumes: called right after a rising edge
// Notes: released address and data are inverted so stale values never match
module asd_seq_model (
  input wire logic clk, // clock
  output logic psel, // select
  output logic penable, // access
  output logic pwrite, // direction
  output logic [7:0] paddr, // address
  output logic [31:0] pwdata, // write data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic [31:0] prdata // read data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic late);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (!pready && n < 50);
    late = !pready;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk);
  endtask
endmodule
